// File: inc/sbp_pkg.sv
package sbp_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int RADDR_W = 6;
  localparam int WAIT_W  = 4;

  // ------------------------------------------------------------
  // Levels and reset values
  // ------------------------------------------------------------
  localparam logic MRW_READ        = 1'b1;
  localparam logic SWR_READ        = 1'b1;
  localparam logic MODE_STROBE_LOW = 1'b1;
  localparam logic PIN_IDLE_N      = 1'b1;
  localparam logic [1:0] ACK_PAIR_ON = 2'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SEL_GAP_NS      = 10;
  localparam int SEL_GAP_CYC     =
    (SEL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  typedef enum {MS_IDLE, MS_T1, MS_T2, MS_TEND} sbp_mst_state_t;
  typedef enum {SL_IDLE, SL_WAIT, SL_REG, SL_MEM} sbp_slv_state_t;

endpackage

// File: inc/sbp_mst_if.sv
`timescale 1ns/100ps
interface sbp_mst_if;
  import sbp_pkg::*;
  logic                start;
  logic [ADDR_W-1:0]   addr;
  logic [WAIT_W-1:0]   wait_states;
  logic                busy;
  logic                done;
  logic [DATA_W-1:0]   rdata;

  modport ctrl (output start, output addr, output wait_states,
                input busy, input done, input rdata);
  modport eng  (input start, input addr, input wait_states,
                output busy, output done, output rdata);
endinterface

// File: src/sbp_master_eng.sv
`timescale 1ns/100ps
module sbp_master_eng (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Request side
  sbp_mst_if.eng                           m,
  // Bus pins
  output      logic [sbp_pkg::ADDR_W-1:0]  mem_addr,
  output      logic                        early_cycle_start_n,
  output      logic                        addr_strobe_n,
  output      logic                        data_strobe_n,
  output      logic                        mem_read_write,
  input  wire logic [sbp_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic [1:0]                  async_ack_pair_n,
  input  wire logic                        sync_terminate_n
);
  import sbp_pkg::*;

  sbp_mst_state_t    state_q;
  logic [1:0]        ack_s1_q;
  logic [1:0]        ack_s2_q;
  logic [WAIT_W-1:0] wcnt_q;
  logic              extra_q;
  logic              done_q;
  logic [DATA_W-1:0] rdata_q;
  logic              mrw_q;
  logic              ack_seen;

  // ------------------------------------------------------------
  // Termination inputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    ack_s1_q <= async_ack_pair_n;
    ack_s2_q <= ack_s1_q;
  end
  assign ack_seen = (ack_s2_q == ACK_PAIR_ON);

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= MS_IDLE;
      wcnt_q  <= '0;
      extra_q <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
      mem_addr <= '0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        MS_IDLE: begin
          extra_q <= 1'b0;
          if (m.start) begin
            state_q  <= MS_T1;
            mem_addr <= m.addr;
            wcnt_q   <= m.wait_states;
          end
        end
        MS_T1: begin
          if (ack_seen && wcnt_q == '0) begin
            state_q <= MS_TEND;
          end else begin
            state_q <= MS_T2;
          end
        end
        MS_T2: begin
          if (wcnt_q != '0) begin
            wcnt_q  <= wcnt_q - 1'b1;
            extra_q <= 1'b1;
          end else if (!sync_terminate_n) begin
            state_q <= MS_IDLE;
            rdata_q <= mem_rdata;
            done_q  <= 1'b1;
            extra_q <= 1'b0;
          end else if (ack_seen) begin
            state_q <= MS_TEND;
          end else begin
            extra_q <= 1'b1;
          end
        end
        MS_TEND: begin
          state_q <= MS_IDLE;
          extra_q <= 1'b0;
          rdata_q <= mem_rdata;
          done_q  <= 1'b1;
        end
      endcase
    end
  end

  // Only reads are run, so the direction never leaves the read level.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mrw_q <= MRW_READ;
    end else begin
      mrw_q <= MRW_READ;
    end
  end

  // ------------------------------------------------------------
  // Strobes
  // ------------------------------------------------------------
  assign mem_read_write      = mrw_q;
  assign early_cycle_start_n = !(state_q == MS_T1);
  assign addr_strobe_n       = (state_q == MS_IDLE);
  assign data_strobe_n       = !extra_q;
  // A synchronized acknowledge from the last cycle would end the next
  // one at once, so no new cycle starts until it has drained.
  assign m.busy              = (state_q != MS_IDLE) || ack_seen;
  assign m.done              = done_q;
  assign m.rdata             = rdata_q;
endmodule

// File: src/sbp_port.sv
`timescale 1ns/100ps
module sbp_port (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Master read requests from the core
  input  wire logic                         rd_req,
  input  wire logic [sbp_pkg::ADDR_W-1:0]   rd_addr,
  input  wire logic [sbp_pkg::WAIT_W-1:0]   rd_wait_states,
  output      logic                         rd_accept,
  output      logic [sbp_pkg::DATA_W-1:0]   rd_data,
  output      logic                         rd_valid,
  // Master bus pins
  output      logic [sbp_pkg::ADDR_W-1:0]   mem_addr,
  output      logic                         early_cycle_start_n,
  output      logic                         addr_strobe_n,
  output      logic                         data_strobe_n,
  output      logic                         mem_read_write,
  input  wire logic [sbp_pkg::DATA_W-1:0]   mem_rdata,
  input  wire logic [1:0]                   async_ack_pair_n,
  input  wire logic                         sync_terminate_n,
  // Slave bus pins
  input  wire logic                         chip_sel_n,
  input  wire logic                         slave_addr_strobe,
  input  wire logic                         slave_write_read,
  input  wire logic [sbp_pkg::RADDR_W-1:0]  reg_addr_pin,
  input  wire logic                         shared_mem_request_n,
  input  wire logic                         bus_mode_sel,
  input  wire logic [sbp_pkg::DATA_W-1:0]   reg_data_in,
  output      logic [sbp_pkg::DATA_W-1:0]   reg_data_out,
  output      logic                         reg_data_oe,
  output      logic                         slave_mem_ack_n,
  output      logic                         ready_out_n,
  // Register access toward the core
  input  wire logic [sbp_pkg::DATA_W-1:0]   core_rdata,
  output      logic                         reg_access_start,
  output      logic [sbp_pkg::RADDR_W-1:0]  reg_access_addr,
  output      logic                         reg_access_write,
  output      logic [sbp_pkg::DATA_W-1:0]   reg_access_wdata,
  output      logic                         shared_mem_grant
);
  import sbp_pkg::*;

  sbp_mst_if mif ();

  // ------------------------------------------------------------
  // Pin synchronizers
  // ------------------------------------------------------------
  logic [3:0]         ctl_s1_q;
  logic [3:0]         ctl_s2_q;
  logic [RADDR_W-1:0] addr_s1_q;
  logic [RADDR_W-1:0] addr_s2_q;
  logic               dir_s1_q;
  logic               dir_s2_q;
  logic [DATA_W-1:0]  wd_s1_q;
  logic [DATA_W-1:0]  wd_s2_q;
  logic               cs_n_s;
  logic               sas_s;
  logic               shared_mem_request_n_n_s;
  logic               mode_s;

  // The host need not meet setup on these; two stages absorb it.
  always_ff @(posedge clk) begin
    ctl_s1_q <= {bus_mode_sel, shared_mem_request_n,
                 slave_addr_strobe, chip_sel_n};
    ctl_s2_q <= ctl_s1_q;
  end

  // Address, direction and data ride the same delay as the strobe.
  always_ff @(posedge clk) begin
    addr_s1_q <= reg_addr_pin;
    addr_s2_q <= addr_s1_q;
    dir_s1_q  <= slave_write_read;
    dir_s2_q  <= dir_s1_q;
    wd_s1_q   <= reg_data_in;
    wd_s2_q   <= wd_s1_q;
  end

  assign cs_n_s   = ctl_s2_q[0];
  assign sas_s    = ctl_s2_q[1];
  assign shared_mem_request_n_n_s = ctl_s2_q[2];
  assign mode_s   = ctl_s2_q[3];

  // ------------------------------------------------------------
  // Select decode
  // ------------------------------------------------------------
  logic sas_act;
  logic reg_sel;
  logic mem_sel;

  // Strobe polarity follows the bus mode input.
  assign sas_act = (mode_s == MODE_STROBE_LOW) ? !sas_s : sas_s;
  assign reg_sel = !cs_n_s && sas_act;
  assign mem_sel = !shared_mem_request_n_n_s;

  // ------------------------------------------------------------
  // Address capture on strobe rise
  // ------------------------------------------------------------
  logic               sas_prev_q;
  logic               sas_rise;
  logic               start_q;
  logic [RADDR_W-1:0] acc_addr_q;
  logic               acc_dir_q;
  logic [DATA_W-1:0]  acc_wd_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Starting high means no rise can be seen on the first edge.
      sas_prev_q <= 1'b1;
    end else begin
      sas_prev_q <= sas_s;
    end
  end
  assign sas_rise = sas_s && !sas_prev_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_addr_q <= '0;
      acc_dir_q  <= SWR_READ;
      acc_wd_q   <= '0;
      start_q    <= 1'b0;
    end else begin
      start_q <= sas_rise && !cs_n_s;
      if (sas_rise) begin
        acc_addr_q <= addr_s2_q;
        acc_dir_q  <= dir_s2_q;
        acc_wd_q   <= wd_s2_q;
      end
    end
  end

  assign reg_access_start = start_q;
  assign reg_access_addr  = acc_addr_q;
  assign reg_access_write = (acc_dir_q != SWR_READ);
  assign reg_access_wdata = acc_wd_q;

  // ------------------------------------------------------------
  // Slave acknowledge sequencer
  // ------------------------------------------------------------
  sbp_slv_state_t sl_q;
  sbp_slv_state_t sl_d;

  // A slave request waits out any master cycle in progress, so its
  // latency grows with that cycle's wait states.
  always_comb begin
    sl_d = sl_q;
    unique case (sl_q)
      SL_IDLE: begin
        if (reg_sel || mem_sel) begin
          if (mif.busy) begin
            sl_d = SL_WAIT;
          end else if (reg_sel) begin
            sl_d = SL_REG;
          end else begin
            sl_d = SL_MEM;
          end
        end
      end
      SL_WAIT: begin
        if (!reg_sel && !mem_sel) begin
          sl_d = SL_IDLE;
        end else if (!mif.busy) begin
          sl_d = reg_sel ? SL_REG : SL_MEM;
        end
      end
      SL_REG: begin
        if (!reg_sel) begin
          sl_d = SL_IDLE;
        end
      end
      SL_MEM: begin
        if (!mem_sel) begin
          sl_d = SL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sl_q <= SL_IDLE;
    end else begin
      sl_q <= sl_d;
    end
  end

  // ------------------------------------------------------------
  // Slave outputs
  // ------------------------------------------------------------
  logic              ack_n_q;
  logic              rdy_n_q;
  logic              oe_q;
  logic              grant_q;
  logic [DATA_W-1:0] rdo_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_n_q <= PIN_IDLE_N;
      rdy_n_q <= PIN_IDLE_N;
      oe_q    <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      ack_n_q <= !(sl_d == SL_REG || sl_d == SL_MEM);
      rdy_n_q <= !(sl_d == SL_REG);
      oe_q    <= (sl_d == SL_REG) && (dir_s2_q == SWR_READ);
      grant_q <= (sl_d == SL_MEM);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdo_q <= '0;
    end else if (sl_d == SL_REG) begin
      rdo_q <= core_rdata;
    end
  end

  assign slave_mem_ack_n  = ack_n_q;
  assign ready_out_n      = rdy_n_q;
  assign reg_data_oe      = oe_q;
  assign reg_data_out     = rdo_q;
  assign shared_mem_grant = grant_q;

  // ------------------------------------------------------------
  // Master request path
  // ------------------------------------------------------------
  // New master cycles are held off while any slave request stands,
  // which is what keeps the slave latency bounded.
  assign rd_accept = !mif.busy && sl_q == SL_IDLE
                     && !reg_sel && !mem_sel;
  assign mif.start       = rd_req && rd_accept;
  assign mif.addr        = rd_addr;
  assign mif.wait_states = rd_wait_states;
  assign rd_valid        = mif.done;
  assign rd_data         = mif.rdata;

  sbp_master_eng u_eng (
    .clk                 (clk),
    .resetn              (resetn),
    .m                   (mif),
    .mem_addr            (mem_addr),
    .early_cycle_start_n (early_cycle_start_n),
    .addr_strobe_n       (addr_strobe_n),
    .data_strobe_n       (data_strobe_n),
    .mem_read_write      (mem_read_write),
    .mem_rdata           (mem_rdata),
    .async_ack_pair_n    (async_ack_pair_n),
    .sync_terminate_n    (sync_terminate_n)
  );
endmodule

// File: sim/sbp_port_props.sv
`timescale 1ns/100ps
module sbp_port_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Master side
  input wire logic       rd_req,
  input wire logic       rd_accept,
  input wire logic [sbp_pkg::WAIT_W-1:0] rd_wait_states,
  input wire logic       rd_valid,
  input wire logic       early_cycle_start_n,
  input wire logic       addr_strobe_n,
  input wire logic       data_strobe_n,
  input wire logic       mem_read_write,
  input wire logic [1:0] async_ack_pair_n,
  input wire logic       sync_terminate_n,
  // Slave side
  input wire logic       chip_sel_n,
  input wire logic       slave_addr_strobe,
  input wire logic       shared_mem_request_n,
  input wire logic       bus_mode_sel,
  input wire logic       reg_data_oe,
  input wire logic       slave_mem_ack_n,
  input wire logic       ready_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Programmed waits still to run in the current master cycle.
  logic [sbp_pkg::WAIT_W-1:0] wait_left_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_left_q <= '0;
    end else if (rd_req && rd_accept) begin
      wait_left_q <= rd_wait_states;
    end else if (!addr_strobe_n && early_cycle_start_n &&
                 wait_left_q != '0) begin
      wait_left_q <= wait_left_q - 1'b1;
    end
  end

  property p_mrw; mem_read_write == 1'b1; endproperty
  property p_ecs; !early_cycle_start_n |=>
    early_cycle_start_n && !addr_strobe_n; endproperty
  property p_ds; !data_strobe_n |->
    !addr_strobe_n && early_cycle_start_n; endproperty
  property p_sync_terminate_n;
    !addr_strobe_n && early_cycle_start_n && !sync_terminate_n &&
    wait_left_q == '0 |=> rd_valid; endproperty
  property p_wait; (!addr_strobe_n && sync_terminate_n &&
    async_ack_pair_n == 2'h3)[*3] |=> !addr_strobe_n; endproperty
  property p_msync; $fell(shared_mem_request_n) && slave_mem_ack_n
    |=> slave_mem_ack_n; endproperty
  property p_mlat; $fell(shared_mem_request_n) && chip_sel_n &&
    addr_strobe_n && !rd_req |-> ##[1:5] !slave_mem_ack_n; endproperty
  property p_mhold; !shared_mem_request_n && !slave_mem_ack_n
    |=> !slave_mem_ack_n; endproperty
  property p_csrel; $rose(chip_sel_n) && shared_mem_request_n
    |-> ##[1:4] (slave_mem_ack_n && ready_out_n && !reg_data_oe);
  endproperty
  property p_sasrel; $changed(slave_addr_strobe) &&
    slave_addr_strobe == bus_mode_sel && shared_mem_request_n
    |-> ##[1:4] slave_mem_ack_n; endproperty
  property p_rdy; !ready_out_n |-> !slave_mem_ack_n; endproperty

  a_mrw: assert property (p_mrw)
    else $error("direction left read level");
  a_ecs: assert property (p_ecs)
    else $error("early start not one cycle");
  a_ds: assert property (p_ds)
    else $error("data strobe outside wait");
  a_sync_terminate_n: assert property (p_sync_terminate_n)
    else $error("terminate did not end cycle");
  a_wait: assert property (p_wait)
    else $error("cycle ended without termination");
  a_msync: assert property (p_msync)
    else $error("request not synchronized");
  a_mlat: assert property (p_mlat)
    else $error("memory ack too late");
  a_mhold: assert property (p_mhold)
    else $error("memory ack dropped");
  a_csrel: assert property (p_csrel)
    else $error("outputs held after select off");
  a_sasrel: assert property (p_sasrel)
    else $error("ack held after strobe off");
  a_rdy: assert property (p_rdy)
    else $error("ready without ack");

  c_sync_terminate_n: cover property (!sync_terminate_n && !addr_strobe_n);
  c_async: cover property (async_ack_pair_n == 2'h0 && !addr_strobe_n);
  c_reg: cover property (!slave_mem_ack_n && !chip_sel_n);
endmodule

bind sbp_port sbp_port_props u_props (.clk, .resetn, .rd_req,
  .rd_accept, .rd_wait_states,
  .rd_valid, .early_cycle_start_n, .addr_strobe_n, .data_strobe_n,
  .mem_read_write, .async_ack_pair_n, .sync_terminate_n, .chip_sel_n,
  .slave_addr_strobe, .shared_mem_request_n, .bus_mode_sel,
  .reg_data_oe, .slave_mem_ack_n, .ready_out_n);

// File: sim/sbp_mem_model.sv
`timescale 1ns/100ps
module sbp_mem_model (
  // Clock and answer style
  input  wire logic [0:0]                 clk,
  input  wire logic                       use_sync,
  input  wire logic [sbp_pkg::WAIT_W-1:0] delay,
  // Bus pins
  input  wire logic [sbp_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                       addr_strobe_n,
  output      logic [sbp_pkg::DATA_W-1:0] mem_rdata,
  output      logic [1:0]                 async_ack_pair_n,
  output      logic                       sync_terminate_n
);
  import sbp_pkg::*;
  logic [WAIT_W-1:0] cnt_q = '0;
  initial begin
    mem_rdata = '0;
    async_ack_pair_n = 2'h3;
    sync_terminate_n = 1'b1;
  end
  // Answers after a set count, holds until the strobe goes away;
  // data outside the answer toggles so stale values never match.
  always @(negedge clk) begin
    if (addr_strobe_n) begin
      cnt_q <= '0;
      async_ack_pair_n <= 2'h3;
      sync_terminate_n <= 1'b1;
      mem_rdata <= ~mem_rdata;
    end else if (cnt_q >= delay) begin
      if (use_sync) sync_terminate_n <= 1'b0;
      else async_ack_pair_n <= 2'h0;
      mem_rdata <= ~mem_addr;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// File: sim/sbp_port_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module sbp_port_tb_top;
  import sbp_pkg::*;
  logic clk, resetn, rd_req, rd_accept, rd_valid, early_cycle_start_n;
  logic addr_strobe_n, data_strobe_n, mem_read_write, sync_terminate_n;
  logic chip_sel_n, slave_addr_strobe, slave_write_read, bus_mode_sel;
  logic shared_mem_request_n, reg_data_oe, slave_mem_ack_n, use_sync;
  logic ready_out_n, reg_access_start, reg_access_write;
  logic shared_mem_grant;
  logic [ADDR_W-1:0]  rd_addr, mem_addr;
  logic [DATA_W-1:0]  rd_data, mem_rdata, reg_data_in, reg_data_out;
  logic [DATA_W-1:0]  core_rdata, reg_access_wdata;
  logic [WAIT_W-1:0]  rd_wait_states, dly;
  logic [1:0]         async_ack_pair_n;
  logic [RADDR_W-1:0] reg_addr_pin, reg_access_addr;
  int num_errors = 0, n_checks = 0, cyc = 0;

  sbp_port DUT (.clk, .resetn, .rd_req, .rd_addr, .rd_wait_states,
    .rd_accept, .rd_data, .rd_valid, .mem_addr, .early_cycle_start_n,
    .addr_strobe_n, .data_strobe_n, .mem_read_write, .mem_rdata,
    .async_ack_pair_n, .sync_terminate_n, .chip_sel_n,
    .slave_addr_strobe, .slave_write_read, .reg_addr_pin,
    .shared_mem_request_n, .bus_mode_sel, .reg_data_in, .reg_data_out,
    .reg_data_oe, .slave_mem_ack_n, .ready_out_n, .core_rdata,
    .reg_access_start, .reg_access_addr, .reg_access_write,
    .reg_access_wdata, .shared_mem_grant);
  sbp_mem_model u_mem (.clk, .use_sync, .delay(dly), .mem_addr,
    .addr_strobe_n, .mem_rdata, .async_ack_pair_n, .sync_terminate_n);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_ack(input logic lvl, input int mx, output int n);
    n = 0;
    while (slave_mem_ack_n !== lvl && n < mx) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic take(input logic [ADDR_W-1:0] a);
    rd_addr = a;
    rd_req = 1'b1;
    while (rd_accept !== 1'b1) @(negedge clk);
    @(negedge clk);
    rd_req = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic s,
      input logic [WAIT_W-1:0] d, output int lat, output logic ds);
    lat = 0;
    ds = 1'b0;
    use_sync = s;
    dly = d;
    take(a);
    while (rd_valid !== 1'b1 && lat < 40) begin
      if (data_strobe_n === 1'b0) ds = 1'b1;
      @(negedge clk);
      lat++;
    end
    `CHK(rd_data, ~a, "read data")
  endtask

  task automatic t_master;
    int ls1, ls4, la1, la4;
    logic d1, d4, dx;
    rd(32'h0000_1000, 1'b1, 4'h1, ls1, d1);
    rd(32'h0000_1004, 1'b1, 4'h4, ls4, d4);
    rd(32'h0000_1008, 1'b0, 4'h1, la1, dx);
    rd(32'h0000_100C, 1'b0, 4'h4, la4, dx);
    `CHK(ls4 - ls1, 3, "terminate wait count")
    `CHK(ls1, 2, "two clock access")
    `CHK(la4 - la1, 3, "ack wait count")
    `CHK(la1 > ls1, 1'b1, "ack not synchronized")
    `CHK(d1, 1'b0, "data strobe without wait")
    `CHK(d4, 1'b1, "no data strobe in wait")
    rd_wait_states = 4'h2;
    rd(32'hFFFF_FFFC, 1'b1, 4'h1, ls1, d1);
    `CHK(d1, 1'b1, "no data strobe with waits")
  endtask

  task automatic t_reg(input logic m, input logic w);
    int n;
    bus_mode_sel = m;
    slave_addr_strobe = m;
    slave_write_read = ~w;
    reg_addr_pin = {w, 5'h15};
    step(3);
    chip_sel_n = 1'b0;
    slave_addr_strobe = ~m;
    wait_ack(1'b0, 8, n);
    `CHK(n <= 4, 1'b1, "register ack latency")
    `CHK(reg_access_start, ~m, "start at strobe rise")
    step(2);
    `CHK(ready_out_n, 1'b0, "ready not driven")
    `CHK(reg_data_oe, ~w, "data bus drive")
    if (!w) `CHK(reg_data_out, 32'h0F1E_2D3C, "read data")
    slave_addr_strobe = m;
    wait_ack(1'b1, 8, n);
    `CHK(n <= 4, 1'b1, "ack held past strobe")
    `CHK(reg_access_start, m, "start at strobe rise")
    step(3);
    `CHK(reg_data_oe, 1'b0, "data bus kept")
    `CHK(reg_access_addr, {w, 5'h15}, "address")
    `CHK(reg_access_write, w, "direction")
    if (w) `CHK(reg_access_wdata, 32'h3C5A_96E1, "write data")
    slave_addr_strobe = ~m;
    wait_ack(1'b0, 8, n);
    `CHK(n <= 4, 1'b1, "second access ack")
    chip_sel_n = 1'b1;
    wait_ack(1'b1, 8, n);
    `CHK({n <= 4, ready_out_n}, 2'h3, "select off")
    slave_addr_strobe = m;
    step(2);
  endtask

  task automatic t_mem;
    int n;
    int hi;
    hi = 0;
    shared_mem_request_n = 1'b0;
    wait_ack(1'b0, 8, n);
    `CHK(n <= 5, 1'b1, "memory ack latency")
    repeat (10) begin
      @(negedge clk);
      if (slave_mem_ack_n !== 1'b0) hi++;
    end
    `CHK(hi, 0, "memory ack dropped")
    `CHK(shared_mem_grant, 1'b1, "grant missing")
    shared_mem_request_n = 1'b1;
    wait_ack(1'b1, 8, n);
    `CHK(n <= 4, 1'b1, "memory ack release")
  endtask

  task automatic t_busy;
    int n;
    bus_mode_sel = 1'b1;
    slave_addr_strobe = 1'b1;
    step(3);
    use_sync = 1'b0;
    dly = 4'h6;
    take(32'h0000_2000);
    chip_sel_n = 1'b0;
    slave_addr_strobe = 1'b0;
    wait_ack(1'b0, 24, n);
    `CHK(n < 24, 1'b1, "ack during master cycle")
    `CHK(rd_accept, 1'b0, "master not held off")
    slave_addr_strobe = 1'b1;
    chip_sel_n = 1'b1;
    step(12);
  endtask

  initial begin
    resetn = 1'b0;
    rd_req = 1'b0;
    rd_addr = '0;
    rd_wait_states = 4'h0;
    chip_sel_n = 1'b1;
    slave_addr_strobe = 1'b1;
    slave_write_read = 1'b1;
    reg_addr_pin = '0;
    shared_mem_request_n = 1'b1;
    bus_mode_sel = 1'b1;
    reg_data_in = 32'h3C5A_96E1;
    core_rdata = 32'h0F1E_2D3C;
    use_sync = 1'b0;
    dly = 4'h0;
    step(5);
    resetn = 1'b1;
    step(2);
    t_master;
    t_reg(1'b1, 1'b0);
    t_reg(1'b1, 1'b1);
    t_reg(1'b0, 1'b0);
    t_mem;
    t_busy;
    close_out();
  end
endmodule
